// ---- led_load_model.sv ----
// Model of the LED loads on the PWM pins: remembers which channels have lit
`default_nettype none
module led_load_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pins and bench control
   input wire logic [7:0] led_pwm,
   input wire logic clr,
   output logic [7:0] seen_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Sticky record of lit channels
   logic [7:0] seen_r;
   logic [7:0] seen_nxt;
   // A load cannot report a glitch, so only whole-cycle levels are recorded
   always_comb begin
      seen_nxt = clr ? 8'h00 : (seen_r | led_pwm);
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_r <= 8'h00;
      end else begin
         seen_r <= seen_nxt;
      end
   end
   assign seen_on = seen_r;
endmodule : led_load_model
`default_nettype wire

// ---- led_player.sv ----
// LED section player: AHB-Lite registers, sample sequencer, halt gating
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`default_nettype none
module led_player (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Halt handshake from the core
   input wire logic halt_req,
   output logic halt_grant,
   // LED pins and interrupt
   output logic [7:0] led_pwm,
   output logic irq
);
   import led_player_pkg::*;

   pwm_if pw ();

   pwm_bank u_bank (
      .hclk(hclk),
      .hresetn(hresetn),
      .pw(pw.bank)
   );

   // ==========================================================
   // State
   player_state_t st_r, st_nxt;
   logic [1:0] ext_r, ext_nxt;
   logic hold_r, hold_nxt;
   logic busy_r, busy_nxt;
   logic [3:0] en_lo_r, en_lo_nxt;
   logic [3:0] en_hi_r, en_hi_nxt;
   logic [1:0] stat_r, stat_nxt;
   logic [1:0] mask_r, mask_nxt;
   logic irq_r, irq_nxt;
   logic [3:0] start_r, start_nxt;
   logic [3:0] ptr_r, ptr_nxt;
   logic [8:0] fcnt_r, fcnt_nxt;
   logic [7:0] duty_r, duty_nxt;
   logic [SMP_W-1:0] smp_mem [SMP_DEPTH];
   logic hreq_s1_r, hreq_s2_r;
   logic grant_r, grant_nxt;
   logic ap_valid_r, ap_valid_nxt;
   logic ap_write_r, ap_write_nxt;
   logic [7:0] ap_addr_r, ap_addr_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   logic ap_take;
   logic wr_en;
   logic do_play, do_stop;
   logic [SMP_W-1:0] cur_smp;
   logic sample_done;

   assign ap_take = hsel && hready && htrans[1];
   assign wr_en = ap_valid_r && ap_write_r;
   assign do_play = wr_en && (ap_addr_r == OFF_CMD) && hwdata[CMD_PLAY_BIT];
   assign do_stop = wr_en && (ap_addr_r == OFF_CMD) && hwdata[CMD_STOP_BIT];
   assign cur_smp = smp_mem[ptr_r];
   assign sample_done = pw.frame_end && (fcnt_r + 9'h001 >= sample_frames(cur_smp[9:8], ext_r));

   // ==========================================================
   // Bus, registers and sequencer next state
   always_comb begin
      ap_valid_nxt = ap_take;
      ap_write_nxt = ap_take ? hwrite : ap_write_r;
      ap_addr_nxt = ap_take ? haddr[7:0] : ap_addr_r;
      ext_nxt = ext_r;
      hold_nxt = hold_r;
      en_lo_nxt = en_lo_r;
      en_hi_nxt = en_hi_r;
      mask_nxt = mask_r;
      start_nxt = start_r;
      stat_nxt = stat_r;
      st_nxt = st_r;
      busy_nxt = busy_r;
      ptr_nxt = ptr_r;
      fcnt_nxt = fcnt_r;
      duty_nxt = duty_r;
      // Software writes land in the data phase
      if (wr_en) begin
         if (ap_addr_r == OFF_CTRL) begin
            ext_nxt = hwdata[1:0];
            hold_nxt = hwdata[CTRL_HOLD_BIT];
         end else if (ap_addr_r == OFF_EN_LO) begin
            en_lo_nxt = hwdata[3:0];
         end else if (ap_addr_r == OFF_EN_HI) begin
            en_hi_nxt = hwdata[3:0];
         end else if (ap_addr_r == OFF_STATUS) begin
            stat_nxt = stat_r & ~hwdata[1:0];
         end else if (ap_addr_r == OFF_MASK) begin
            mask_nxt = hwdata[1:0];
         end else if (ap_addr_r == OFF_START) begin
            start_nxt = hwdata[3:0];
         end
      end
      case (st_r)
         PL_IDLE: begin
            if (do_play) begin
               st_nxt = PL_PLAY;
               busy_nxt = 1'b1;
               ptr_nxt = start_r;
               fcnt_nxt = 9'h000;
               duty_nxt = smp_mem[start_r][7:0];
            end
         end
         PL_PLAY: begin
            if (pw.frame_end && hold_r) begin
               st_nxt = PL_HELD;
               busy_nxt = 1'b0;
               stat_nxt[ST_HOLD_BIT] = 1'b1;
            end else if (sample_done) begin
               fcnt_nxt = 9'h000;
               if (cur_smp[SMP_LAST_BIT]) begin
                  st_nxt = PL_IDLE;
                  busy_nxt = 1'b0;
                  stat_nxt[ST_END_BIT] = 1'b1;
               end else begin
                  ptr_nxt = ptr_r + 4'h1;
                  duty_nxt = smp_mem[ptr_r + 4'h1][7:0];
               end
            end else if (pw.frame_end) begin
               fcnt_nxt = fcnt_r + 9'h001;
            end
         end
         PL_HELD: begin
            // Duty stays put, the bank keeps repeating frames
            if (!hold_r) begin
               st_nxt = PL_PLAY;
               busy_nxt = 1'b1;
            end
         end
         default: st_nxt = PL_IDLE;
      endcase
      if (do_stop) begin
         st_nxt = PL_IDLE;
         busy_nxt = 1'b0;
         duty_nxt = 8'h00;
         stat_nxt[ST_END_BIT] = 1'b0;
      end
      irq_nxt = |(stat_r & mask_r);
      // Halt waits for a player that is not busy, idle or held
      grant_nxt = hreq_s2_r && !busy_r;
      rdata_nxt = 32'h0000_0000;
      if (ap_take && !hwrite) begin
         if (haddr[7:0] == OFF_CTRL) begin
            rdata_nxt = {28'h000_0000, busy_r, hold_r, ext_r};
         end else if (haddr[7:0] == OFF_EN_LO) begin
            rdata_nxt = {28'h000_0000, en_lo_r};
         end else if (haddr[7:0] == OFF_EN_HI) begin
            rdata_nxt = {28'h000_0000, en_hi_r};
         end else if (haddr[7:0] == OFF_STATUS) begin
            rdata_nxt = {30'h0000_0000, stat_r};
         end else if (haddr[7:0] == OFF_MASK) begin
            rdata_nxt = {30'h0000_0000, mask_r};
         end else if (haddr[7:0] == OFF_START) begin
            rdata_nxt = {28'h000_0000, start_r};
         end else if (haddr[7:0] == OFF_POS) begin
            rdata_nxt = {15'h0000, fcnt_r, 4'h0, ptr_r};
         end else if (haddr[7:6] == OFF_SAMPLE[7:6]) begin
            rdata_nxt = {21'h00_0000, smp_mem[haddr[5:2]]};
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= PL_IDLE;
         ext_r <= CTRL_RST[1:0];
         hold_r <= CTRL_RST[CTRL_HOLD_BIT];
         busy_r <= CTRL_RST[CTRL_BUSY_BIT];
         en_lo_r <= EN_RST;
         en_hi_r <= EN_RST;
         stat_r <= IRQ_RST;
         mask_r <= IRQ_RST;
         irq_r <= 1'b0;
         start_r <= 4'h0;
         ptr_r <= 4'h0;
         fcnt_r <= 9'h000;
         duty_r <= 8'h00;
         hreq_s1_r <= 1'b0;
         hreq_s2_r <= 1'b0;
         grant_r <= 1'b0;
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
         ext_r <= ext_nxt;
         hold_r <= hold_nxt;
         busy_r <= busy_nxt;
         en_lo_r <= en_lo_nxt;
         en_hi_r <= en_hi_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
         start_r <= start_nxt;
         ptr_r <= ptr_nxt;
         fcnt_r <= fcnt_nxt;
         duty_r <= duty_nxt;
         hreq_s1_r <= halt_req;
         hreq_s2_r <= hreq_s1_r;
         grant_r <= grant_nxt;
         ap_valid_r <= ap_valid_nxt;
         ap_write_r <= ap_write_nxt;
         ap_addr_r <= ap_addr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Sample store has no reset; software loads it before play
   always_ff @(posedge hclk) begin
      if (wr_en && (ap_addr_r[7:6] == OFF_SAMPLE[7:6])) begin
         smp_mem[ap_addr_r[5:2]] <= hwdata[SMP_W-1:0];
      end
   end

   assign pw.duty = duty_r;
   assign pw.enables = {en_hi_r, en_lo_r};
   assign led_pwm = pw.pwm_out;
   assign irq = irq_r;
   assign halt_grant = grant_r;
   assign hrdata = rdata_r;
   // Zero wait states and OKAY only, so both are tied to constants
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ==========================================================
   // Checks
   sequence s_stop_cmd;
      do_stop;
   endsequence

   sequence s_idle_quiet;
      !busy_r && (duty_r == 8'h00) && !stat_r[ST_END_BIT];
   endsequence

   chk_stop_clears: assert property (@(posedge hclk) disable iff (!hresetn)
      s_stop_cmd |=> s_idle_quiet)
      else $error("stop did not clear busy, duty and end flag");

   chk_play_busy: assert property (@(posedge hclk) disable iff (!hresetn)
      (do_play && !do_stop && st_r == PL_IDLE) |=> busy_r && st_r == PL_PLAY)
      else $error("play did not raise busy");

   chk_hold_frame: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_r == PL_PLAY && hold_r && !pw.frame_end && !do_stop) |=> busy_r && st_r == PL_PLAY)
      else $error("hold took effect off a frame boundary");

   chk_hold_takes: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_r == PL_PLAY && hold_r && pw.frame_end && !do_stop) |=> !busy_r && st_r == PL_HELD)
      else $error("hold did not take effect at the frame end");

   chk_hold_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_r == PL_HELD && !do_stop) |=> $stable(duty_r))
      else $error("held duty changed");

   chk_resume_busy: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_r == PL_HELD && !hold_r && !do_stop) |=> busy_r ##0 st_r == PL_PLAY)
      else $error("resume did not restart play");

   chk_halt_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      halt_grant |-> $past(!busy_r))
      else $error("halt granted while busy");

   chk_ext_decode: assert property (@(posedge hclk) disable iff (!hresetn)
      ext_factor(ext_r) == (4'h8 >> ext_r))
      else $error("extension decode wrong");

   chk_end_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_r == PL_PLAY && sample_done && !hold_r && cur_smp[SMP_LAST_BIT] && !do_stop)
      |=> stat_r[ST_END_BIT] && !busy_r && st_r == PL_IDLE)
      else $error("section end did not set flag");

   chk_pwm_level: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 led_pwm[0] == $past(pw.enables[0] && pw.pwm_pos < pw.duty))
      else $error("channel 0 level wrong");

   chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 irq == $past(|(stat_r & mask_r)))
      else $error("interrupt level wrong");
endmodule : led_player
`default_nettype wire

// ---- led_player_pkg.sv ----
// Constants, types and helpers shared by the LED section player files
`default_nettype none
package led_player_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_EN_LO = 8'h04;
   localparam logic [7:0] OFF_EN_HI = 8'h08;
   localparam logic [7:0] OFF_CMD = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_MASK = 8'h14;
   localparam logic [7:0] OFF_START = 8'h18;
   localparam logic [7:0] OFF_POS = 8'h1C;
   localparam logic [7:0] OFF_SAMPLE = 8'h40;
   // ==========================================================
   // Field positions
   localparam int CTRL_HOLD_BIT = 2;
   localparam int CTRL_BUSY_BIT = 3;
   localparam int CMD_PLAY_BIT = 0;
   localparam int CMD_STOP_BIT = 1;
   localparam int ST_END_BIT = 0;
   localparam int ST_HOLD_BIT = 1;
   localparam int SMP_CNT_LSB = 8;
   localparam int SMP_LAST_BIT = 10;
   localparam int SMP_W = 11;
   localparam int SMP_DEPTH = 16;
   // ==========================================================
   // Reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [3:0] EN_RST = 4'h0;
   localparam logic [1:0] IRQ_RST = 2'h0;
   // ==========================================================
   // Timing: 8-bit PWM, frame rate 128 Hz, clock 125 MHz
   localparam int CLK_HZ = 125_000_000;
   localparam int FRAME_RATE_HZ = 128;
   localparam int PWM_STEPS = 256;
   localparam int STEP_DIV = CLK_HZ / (FRAME_RATE_HZ * PWM_STEPS);
   localparam logic [11:0] STEP_DIV_M1 = 12'(STEP_DIV - 1);

   typedef enum logic [1:0] {PL_IDLE, PL_PLAY, PL_HELD} player_state_t;

   // Extension code 00..11 -> 8,4,2,1
   function automatic logic [3:0] ext_factor(input logic [1:0] sel);
      case (sel)
         2'b00: ext_factor = 4'h8;
         2'b01: ext_factor = 4'h4;
         2'b10: ext_factor = 4'h2;
         default: ext_factor = 4'h1;
      endcase
   endfunction : ext_factor

   // Frames per sample: per-sample count times extension
   function automatic logic [8:0] sample_frames(input logic [1:0] code, input logic [1:0] sel);
      logic [5:0] n;
      case (code)
         2'b00: n = 6'h01;
         2'b01: n = 6'h02;
         2'b10: n = 6'h08;
         default: n = 6'h20;
      endcase
      // Widen before the product: 32 frames times 8 needs nine bits
      sample_frames = 9'(n) * 9'(ext_factor(sel));
   endfunction : sample_frames
endpackage : led_player_pkg
`default_nettype wire

// ---- led_section_player_control_bench.sv ----
// Self-checking bench for the LED section player
`default_nettype none
module led_section_player_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import led_player_pkg::*;
   // ==========================================================
   // Signals
   logic hclk, hresetn, hsel, hwrite, halt_req, load_clr;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, halt_grant, irq;
   logic [7:0] led_pwm, seen_on;
   wire logic hready;
   int bad_count, n_checks;
   typedef struct packed {logic [3:0] lo; logic [3:0] hi; logic [7:0] duty; logic [7:0] exp;} row_t;
   // Enables and duty beside the pin pattern expected while the frame counter is at step 0
   row_t rows [6] = '{'{4'h1, 4'h0, 8'h80, 8'h01}, '{4'h0, 4'h8, 8'h80, 8'h80},
      '{4'hA, 4'h5, 8'h01, 8'h5A}, '{4'hF, 4'hF, 8'h00, 8'h00},
      '{4'hF, 4'hF, 8'hFF, 8'hFF}, '{4'h5, 4'hA, 8'h10, 8'hA5}};
   logic [7:0] rst_offs [5] = '{OFF_CTRL, OFF_EN_LO, OFF_EN_HI, OFF_STATUS, OFF_MASK};
   assign hready = hreadyout;
   // ==========================================================
   // Instances
   led_player led_player_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .halt_req(halt_req), .halt_grant(halt_grant),
      .led_pwm(led_pwm), .irq(irq));
   led_load_model led_load_model_i (.hclk(hclk), .hresetn(hresetn), .led_pwm(led_pwm), .clr(load_clr),
      .seen_on(seen_on));
   // ==========================================================
   // Tasks
   task automatic give_verdict();
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Waits for the next edge at which hready is seen high, with a bound
   task automatic wait_ready();
      int k;
      k = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         k++;
         if (k > 20) begin
            bad_count++;
            $display("MISMATCH at %0t: bus never ready", $time);
            give_verdict();
         end
         @(posedge hclk);
      end
   endtask : wait_ready
   // One single word transfer; entered just after a rising edge
   task automatic ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr_en;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rdv = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      ahb(1'b1, a, wd);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0000_0000);
      check(rdv, exp);
   endtask : rdchk
   // ==========================================================
   // Clock and overall limit
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      $display("MISMATCH at %0t: run limit reached", $time);
      give_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      halt_req = 1'b0;
      load_clr = 1'b0;
      bad_count = 0;
      n_checks = 0;
      repeat (3) @(posedge hclk);
      check({20'h0_0000, hreadyout, led_pwm, halt_grant, irq, hresp}, 32'h0000_0800);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rst_offs[i]) begin
         rdchk(rst_offs[i], 32'h0000_0000);
      end
      // Extension codes are set while stopped; the busy bit ignores writes
      for (int s = 0; s < 4; s++) begin
         wr(OFF_CTRL, 32'h0000_0008 | 32'(s));
         rdchk(OFF_CTRL, 32'(s));
      end
      wr(OFF_CTRL, 32'h0000_0000);
      wr(8'h20, 32'hFFFF_FFFF);
      rdchk(8'h20, 32'h0000_0000);
      wr(OFF_MASK, 32'h0000_0003);
      rdchk(OFF_MASK, 32'h0000_0003);
      wr(OFF_STATUS, 32'h0000_0003);
      rdchk(OFF_STATUS, 32'h0000_0000);
      check(32'(irq), 32'h0000_0000);
      wr(OFF_START, 32'h0000_0000);
      // All rows run inside the first PWM step, so any nonzero duty lights its enabled channels
      foreach (rows[i]) begin
         wr(OFF_CMD, 32'h0000_0002);
         wr(OFF_EN_LO, {28'h000_0000, rows[i].lo});
         wr(OFF_EN_HI, {28'h000_0000, rows[i].hi});
         wr(OFF_SAMPLE, 32'h0000_0300 | {24'h00_0000, rows[i].duty});
         wr(OFF_CMD, 32'h0000_0001);
         repeat (4) @(posedge hclk);
         check(32'(led_pwm), 32'(rows[i].exp));
         rdchk(OFF_CTRL, 32'h0000_0008);
         rdchk(OFF_EN_HI, {28'h000_0000, rows[i].hi});
      end
      // Hold in mid-frame: busy and pins stand until the frame ends; halt is held off
      load_clr <= 1'b1;
      @(posedge hclk);
      load_clr <= 1'b0;
      wr(OFF_CTRL, 32'h0000_0004);
      halt_req <= 1'b1;
      repeat (20) @(posedge hclk);
      rdchk(OFF_CTRL, 32'h0000_000C);
      check(32'(led_pwm), 32'h0000_00A5);
      check(32'(seen_on), 32'h0000_00A5);
      check(32'(halt_grant), 32'h0000_0000);
      wr(OFF_CTRL, 32'h0000_0000);
      rdchk(OFF_CTRL, 32'h0000_0008);
      check(32'(halt_grant), 32'h0000_0000);
      // Stop ends playback at once and clears the data
      wr(OFF_CMD, 32'h0000_0002);
      repeat (4) @(posedge hclk);
      check(32'(led_pwm), 32'h0000_0000);
      rdchk(OFF_CTRL, 32'h0000_0000);
      rdchk(OFF_STATUS, 32'h0000_0000);
      // Software darkens the upper channels with halt still requested; the grant follows the stop
      wr(OFF_EN_HI, 32'h0000_0000);
      rdchk(OFF_EN_HI, 32'h0000_0000);
      check(32'(halt_grant), 32'h0000_0001);
      halt_req <= 1'b0;
      repeat (5) @(posedge hclk);
      check(32'(halt_grant), 32'h0000_0000);
      // Second reset in mid-run
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      check(32'(led_pwm), 32'h0000_0000);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(OFF_EN_LO, 32'h0000_0000);
      rdchk(OFF_MASK, 32'h0000_0000);
      give_verdict();
   end
endmodule : led_section_player_control_bench
`default_nettype wire

// ---- pwm_bank.sv ----
// Frame timebase and eight 8-bit PWM channel outputs
`default_nettype none
module pwm_bank (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Player side
   pwm_if.bank pw
);
   import led_player_pkg::*;

   logic [11:0] div_r, div_nxt;
   logic [7:0] pos_r, pos_nxt;
   logic fend_r, fend_nxt;
   logic [7:0] out_r, out_nxt;

   // ==========================================================
   // Step divider and frame counter
   always_comb begin
      div_nxt = (div_r == STEP_DIV_M1) ? 12'h000 : div_r + 12'h001;
      pos_nxt = pos_r;
      fend_nxt = 1'b0;
      if (div_r == STEP_DIV_M1) begin
         pos_nxt = pos_r + 8'h01;
         fend_nxt = (pos_r == 8'hFF);
      end
      for (int i = 0; i < 8; i++) begin
         out_nxt[i] = pw.enables[i] && (pos_r < pw.duty);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r <= 12'h000;
         pos_r <= 8'h00;
         fend_r <= 1'b0;
         out_r <= 8'h00;
      end else begin
         div_r <= div_nxt;
         pos_r <= pos_nxt;
         fend_r <= fend_nxt;
         out_r <= out_nxt;
      end
   end

   assign pw.pwm_pos = pos_r;
   assign pw.frame_end = fend_r;
   assign pw.pwm_out = out_r;
endmodule : pwm_bank
`default_nettype wire

// ---- pwm_if.sv ----
// Link between the player sequencer and the PWM channel bank
`default_nettype none
interface pwm_if;
   logic [7:0] duty;
   logic [7:0] enables;
   logic [7:0] pwm_pos;
   logic frame_end;
   logic [7:0] pwm_out;
   modport player (output duty, output enables, input pwm_pos, input frame_end, input pwm_out);
   modport bank (input duty, input enables, output pwm_pos, output frame_end, output pwm_out);
endinterface : pwm_if
`default_nettype wire
